// >>> led_sink_defs.svh
`ifndef LED_SINK_DEFS_SVH
`define LED_SINK_DEFS_SVH
// channel count and configuration code layout
`define CH_COUNT 8
`define CFG_CM_BIT 0
`define CFG_EXP_BIT 1
`define CFG_MANT_LSB 2
`define CFG_MANT_MSB 7
`define CFG_RESET 8'hFF
`define LATCH_RESET 8'h00
`define SREG_RESET 8'h00
// enable history idles high like the pulled-up pin, so no false pulse
`define EN_HIST_RESET 2'h3
// switching sequence: phase lasts two clock periods after the pulse
`define SW_PHASE_CYCLES 2'h2
// low samples before the error vector is written
`define ED_LOAD_COUNT 2'h3
`define ED_SRC_COUNT 2'h2
// current ratio codes
`define RATIO_HIGH 4'hF
`define RATIO_LOW 4'h5
`endif

// >>> led_sink_pkg.sv
package led_sink_pkg;
  typedef enum logic {MODE_NORMAL, MODE_SPECIAL} op_mode_t;
  typedef struct packed {
    logic [5:0] gain_mantissa_field;
    logic gain_exponent_bit;
    logic current_multiplier_bit;
  } cfg_code_t;
endpackage

// >>> led_sink_shift_mode_error_ctrl.sv
// Behaviour
// - three enable samples high, low, high start the switching phase
// - switching phase lasts two clock periods; the mode resolves in its first
// - latch pin high at fourth edge selects Special, else Normal
// - latch pin latches nothing between third and fifth edges
// - low part of switching pulse still enables the sinks
// - shift register keeps shifting during the switching phase
// - Normal mode after reset until Special is selected
// - Normal mode shifts serial input through to serial output
// - Normal mode latch high copies shift register to output latch
// - enable low drives latched channels; high keeps all off
// - Special mode shifts normally while enable is not low
// - Special mode enable low enables sinks and starts detection
// - after second low sample, input source becomes error vector
// - third and later low samples load error vector into shift register
// - enable low in Special mode blocks serial input shifting
// - enable high restores serial source, disables sinks, ends detection
// - captured status shifts out one bit per clock with new data in
// - multiplier bit selects ratio 15 when set, 5 when clear
// - reset gain is 127/128 with multiplier bit one
// - Special mode latch writes configuration latch, held until rewritten
// - code bit0 multiplier, bit1 exponent, bits 2-7 mantissa, bit7 first
// - configuration latch resets to all ones
// - enabled healthy channel reports 1; disabled or open reports 0
`timescale 1ns/1ps
`include "led_sink_defs.svh"
module led_sink_shift_mode_error_ctrl #(
  parameter int CH = `CH_COUNT
) (
  input wire logic i_mclk, // serial shift clock
  input wire logic i_arst_n, // power-on reset, active low
  input wire logic i_serial_in, // serial data in
  input wire logic i_latch_mode_select, // latch strobe / mode select
  input wire logic i_enable_switch_detect_n, // sink enable, active low
  input wire logic [CH-1:0] i_load_ok, // per channel current above threshold
  output logic o_serial_out, // serial data out, last stage
  output logic [CH-1:0] o_led_sink_channel, // sink drive per channel
  output led_sink_pkg::cfg_code_t o_cfg, // configuration latch
  output logic [3:0] o_current_ratio, // output to reference ratio
  output led_sink_pkg::op_mode_t o_mode, // current operating mode
  output logic o_detect_active // error detection running
);
  import led_sink_pkg::*;

  logic [1:0] en_hist_r; // last two enable samples, newest in bit 0
  logic [1:0] sw_cnt_r; // cycles left in switching phase
  logic [1:0] low_cnt_r; // consecutive low samples, saturating
  logic [CH-1:0] sreg_r;
  logic [CH-1:0] out_latch_r;
  logic [CH-1:0] status_vec;
  logic pulse_seen;
  logic sw_active;
  logic in_switch_window;
  logic ed_load;

  // saturating increment shared by the low counter
  function automatic logic [1:0] sat_inc(input logic [1:0] v);
    return (v == 2'h3) ? v : v + 2'h1;
  endfunction

  // sliding window over enable samples; the newest sample is the pin
  assign pulse_seen = en_hist_r[1] & ~en_hist_r[0]
                      & i_enable_switch_detect_n;
  assign sw_active = (sw_cnt_r != 2'h0);
  // edges three to five: the pulse edge plus the two phase cycles
  assign in_switch_window = pulse_seen | sw_active;
  // error vector: enabled and healthy reads 1, else 0
  assign status_vec = out_latch_r & i_load_ok;
  assign ed_load = (o_mode == MODE_SPECIAL) & ~i_enable_switch_detect_n
                   & (low_cnt_r >= `ED_SRC_COUNT);

  // enable sample history
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      en_hist_r <= `EN_HIST_RESET;
    end else begin
      en_hist_r <= {en_hist_r[0], i_enable_switch_detect_n};
    end
  end

  // switching phase timer; a pulse inside a running phase is ignored
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sw_cnt_r <= 2'h0;
    end else if (pulse_seen && !sw_active) begin
      sw_cnt_r <= `SW_PHASE_CYCLES;
    end else if (sw_active) begin
      sw_cnt_r <= sw_cnt_r - 2'h1;
    end
  end

  // mode resolves at the fourth edge, first cycle of the phase
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_mode <= MODE_NORMAL;
    end else if (sw_cnt_r == `SW_PHASE_CYCLES) begin
      o_mode <= i_latch_mode_select ? MODE_SPECIAL : MODE_NORMAL;
    end
  end

  // consecutive low samples of the enable pin
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      low_cnt_r <= 2'h0;
    end else if (i_enable_switch_detect_n) begin
      low_cnt_r <= 2'h0;
    end else begin
      low_cnt_r <= sat_inc(low_cnt_r);
    end
  end

  // shift register: serial in unless error capture owns the input
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sreg_r <= `SREG_RESET;
    end else if (ed_load) begin
      sreg_r <= status_vec;
    end else if (o_mode == MODE_SPECIAL && !i_enable_switch_detect_n) begin
      sreg_r <= sreg_r;
    end else begin
      // first bit in travels to the top stage: bit 7 arrives first
      sreg_r <= {sreg_r[CH-2:0], i_serial_in};
    end
  end

  // serial out is registered copy of the last stage
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_serial_out <= 1'b0;
    end else if (ed_load) begin
      o_serial_out <= status_vec[CH-1];
    end else if (o_mode == MODE_SPECIAL && !i_enable_switch_detect_n) begin
      o_serial_out <= sreg_r[CH-1];
    end else begin
      o_serial_out <= sreg_r[CH-2];
    end
  end

  // output latch: strobe in Normal mode, blocked in switch window
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      out_latch_r <= `LATCH_RESET;
    end else if (i_latch_mode_select && !in_switch_window
                 && o_mode == MODE_NORMAL) begin
      out_latch_r <= sreg_r;
    end
  end

  // configuration latch keeps its code until rewritten
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_cfg <= cfg_code_t'(`CFG_RESET);
    end else if (i_latch_mode_select && !in_switch_window
                 && o_mode == MODE_SPECIAL) begin
      o_cfg <= cfg_code_t'(sreg_r);
    end
  end

  // ratio follows the multiplier bit of the written code
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_current_ratio <= `RATIO_HIGH;
    end else if (i_latch_mode_select && !in_switch_window
                 && o_mode == MODE_SPECIAL) begin
      o_current_ratio <= sreg_r[`CFG_CM_BIT] ? `RATIO_HIGH
                                             : `RATIO_LOW;
    end
  end

  // sinks follow the pin one edge late: a registered output is the trade
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_led_sink_channel <= '0;
    end else if (!i_enable_switch_detect_n) begin
      o_led_sink_channel <= out_latch_r;
    end else begin
      o_led_sink_channel <= '0;
    end
  end

  // detection flag tracks enable low in Special mode
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_detect_active <= 1'b0;
    end else begin
      o_detect_active <= (o_mode == MODE_SPECIAL)
                         & ~i_enable_switch_detect_n;
    end
  end

  // the phase timer runs exactly two cycles after an accepted pulse
  chk_phase_two_cycles: assert property (@(posedge i_mclk)
    disable iff (!i_arst_n)
    (pulse_seen && !sw_active) |=> sw_active ##1 sw_active ##1 !sw_active)
    else $error("switch phase length wrong");

  // latch pin high at the resolving edge selects Special
  chk_mode_special_sel: assert property (@(posedge i_mclk)
    disable iff (!i_arst_n)
    (pulse_seen && !sw_active) ##1 i_latch_mode_select
    |=> o_mode == MODE_SPECIAL)
    else $error("special mode not selected");

  // latch pin low at the resolving edge falls back to Normal
  chk_mode_normal_sel: assert property (@(posedge i_mclk)
    disable iff (!i_arst_n)
    (pulse_seen && !sw_active) ##1 !i_latch_mode_select
    |=> o_mode == MODE_NORMAL)
    else $error("normal mode not selected");

  // outside the resolving edge the mode never moves
  chk_mode_holds: assert property (@(posedge i_mclk)
    disable iff (!i_arst_n)
    (sw_cnt_r != `SW_PHASE_CYCLES) |=> $stable(o_mode))
    else $error("mode changed outside switch");

  // neither latch may move while the switch window is open
  chk_no_latch_window: assert property (@(posedge i_mclk)
    disable iff (!i_arst_n)
    in_switch_window |=> $stable(out_latch_r) && $stable(o_cfg))
    else $error("latch written in switch window");

  // a high enable leaves every sink off at the next edge
  chk_sinks_follow_en: assert property (@(posedge i_mclk)
    disable iff (!i_arst_n)
    i_enable_switch_detect_n |=> o_led_sink_channel == '0)
    else $error("sinks on while disabled");

  // a low enable, short pulse included, hands the latch to the sinks
  chk_sinks_on_low: assert property (@(posedge i_mclk)
    disable iff (!i_arst_n)
    !i_enable_switch_detect_n
    |=> o_led_sink_channel == $past(out_latch_r))
    else $error("sinks not driven while enabled");

  // in Normal mode every edge moves the serial input into stage zero
  chk_shift_normal: assert property (@(posedge i_mclk)
    disable iff (!i_arst_n)
    o_mode == MODE_NORMAL |=> sreg_r[0] == $past(i_serial_in))
    else $error("serial bit not shifted");

  // in Special mode with enable high the whole register moves one stage
  chk_shift_special: assert property (@(posedge i_mclk)
    disable iff (!i_arst_n)
    (o_mode == MODE_SPECIAL && i_enable_switch_detect_n)
    |=> sreg_r == {$past(sreg_r[CH-2:0]), $past(i_serial_in)})
    else $error("special shift broken");

  // serial out always shows the top stage, so the first bit in leads
  chk_serial_top: assert property (@(posedge i_mclk)
    disable iff (!i_arst_n)
    o_serial_out == sreg_r[CH-1])
    else $error("serial out not top stage");

  // third and later low samples in Special load the status vector
  chk_error_load: assert property (@(posedge i_mclk)
    disable iff (!i_arst_n)
    (o_mode == MODE_SPECIAL && !i_enable_switch_detect_n) [*3]
    |=> sreg_r == $past(out_latch_r & i_load_ok))
    else $error("error vector not loaded");

  // the first two low samples in Special let no serial data in
  chk_hold_on_low: assert property (@(posedge i_mclk)
    disable iff (!i_arst_n)
    (o_mode == MODE_SPECIAL && !i_enable_switch_detect_n
     && low_cnt_r < `ED_SRC_COUNT) |=> $stable(sreg_r))
    else $error("serial data entered during low");

  // enable low in Special starts detection on the next edge
  chk_detect_on: assert property (@(posedge i_mclk)
    disable iff (!i_arst_n)
    (o_mode == MODE_SPECIAL && !i_enable_switch_detect_n)
    |=> o_detect_active)
    else $error("detection not started");

  // enable high ends detection on the next edge
  chk_detect_off: assert property (@(posedge i_mclk)
    disable iff (!i_arst_n)
    i_enable_switch_detect_n |=> !o_detect_active)
    else $error("detection still running");

  // a Special strobe writes each code field from its own stage
  chk_cfg_fields: assert property (@(posedge i_mclk)
    disable iff (!i_arst_n)
    (i_latch_mode_select && !in_switch_window && o_mode == MODE_SPECIAL)
    |=> o_cfg.current_multiplier_bit == $past(sreg_r[`CFG_CM_BIT])
        && o_cfg.gain_exponent_bit == $past(sreg_r[`CFG_EXP_BIT])
        && o_cfg.gain_mantissa_field
           == $past(sreg_r[`CFG_MANT_MSB:`CFG_MANT_LSB]))
    else $error("configuration fields misplaced");

  // the ratio register agrees with the stored multiplier bit
  chk_ratio_cm: assert property (@(posedge i_mclk)
    disable iff (!i_arst_n)
    o_current_ratio == (o_cfg.current_multiplier_bit ? `RATIO_HIGH
                                                      : `RATIO_LOW))
    else $error("ratio mismatch");

  // main scenarios: both mode changes, a full error read, a code write
  cov_to_special: cover property (@(posedge i_mclk)
    disable iff (!i_arst_n) $rose(o_mode == MODE_SPECIAL));
  cov_to_normal: cover property (@(posedge i_mclk)
    disable iff (!i_arst_n) $fell(o_mode == MODE_SPECIAL));
  cov_error_read: cover property (@(posedge i_mclk)
    disable iff (!i_arst_n) ed_load ##1 i_enable_switch_detect_n);
  cov_cfg_write: cover property (@(posedge i_mclk)
    disable iff (!i_arst_n) !$stable(o_cfg));
endmodule // led_sink_shift_mode_error_ctrl

// >>> led_load_model.sv
`timescale 1ns/1ps
// eight loads with their current comparators; a channel is judged healthy
// only while it is driven, since an off channel draws no current at all
module led_load_model (
  input wire logic [7:0] i_sink, // sink drive per channel
  input wire logic [7:0] i_open_mask, // channels with a broken load
  output logic [7:0] o_load_ok // current above threshold
);
  // comparator result, healthy only when on and not open
  assign o_load_ok = i_sink & ~i_open_mask;
endmodule // led_load_model

// >>> led_sink_shift_mode_error_ctrl_tb_top.sv
`timescale 1ns/1ps
module led_sink_shift_mode_error_ctrl_tb_top;
  import led_sink_pkg::*;
  logic i_mclk = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_serial_in = 1'b0;
  logic i_latch_mode_select = 1'b0;
  logic i_enable_switch_detect_n = 1'b1;
  logic [7:0] open_mask = 8'h00;
  logic [7:0] load_ok;
  logic [7:0] sink;
  logic [7:0] rd;
  logic so;
  logic det;
  cfg_code_t cfg;
  logic [3:0] ratio;
  op_mode_t mode;
  int n_errors = 0;
  int checks_done = 0;
  // 2 us of low enable at 10 ns per cycle, the capturing edge included
  localparam int ED_HOLD = 201;

  // 100 MHz clock
  always #5 i_mclk = ~i_mclk;

  led_sink_shift_mode_error_ctrl i_dut (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_serial_in(i_serial_in),
    .i_latch_mode_select(i_latch_mode_select),
    .i_enable_switch_detect_n(i_enable_switch_detect_n),
    .i_load_ok(load_ok),
    .o_serial_out(so),
    .o_led_sink_channel(sink),
    .o_cfg(cfg),
    .o_current_ratio(ratio),
    .o_mode(mode),
    .o_detect_active(det)
  );

  led_load_model i_load (
    .i_sink(sink),
    .i_open_mask(open_mask),
    .o_load_ok(load_ok)
  );

  task complete_run;
    if (n_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // every task starts and ends at a falling edge, so inputs never race
  task tick(input int n);
    repeat (n) begin
      @(posedge i_mclk);
      @(negedge i_mclk);
    end
  endtask

  // msb first; the bit leaving is read before the edge that shifts it
  task shift8(input logic [7:0] din, output logic [7:0] dout);
    for (int i = 7; i >= 0; i--) begin
      dout[i] = so;
      i_serial_in = din[i];
      tick(1);
    end
  endtask

  task strobe;
    i_latch_mode_select = 1'b1;
    tick(1);
    i_latch_mode_select = 1'b0;
  endtask

  // one-clock low pulse, then the select level at the resolving edge
  task switch_mode(input logic sel, input logic [7:0] exp_sink);
    i_enable_switch_detect_n = 1'b0;
    tick(1);
    check(sink, exp_sink);
    i_enable_switch_detect_n = 1'b1;
    tick(1);
    i_latch_mode_select = sel;
    tick(1);
    i_latch_mode_select = 1'b0;
    tick(2);
  endtask

  // a hang is cut short here and counted against the run
  initial begin
    #100000;
    $display("[ERR] %0t run timed out", $time);
    n_errors++;
    complete_run;
  end

  initial begin
    repeat (4) @(negedge i_mclk);
    i_arst_n = 1'b1;
    check(cfg, 8'hFF);
    check({4'h0, ratio}, 8'h0F);
    check({7'h00, mode}, 8'h00);
    shift8(8'hA5, rd);
    check(rd, 8'h00);
    strobe();
    check(sink, 8'h00);
    // held low two cycles so the enable does not form a switching pulse
    i_enable_switch_detect_n = 1'b0;
    tick(2);
    check(sink, 8'hA5);
    i_enable_switch_detect_n = 1'b1;
    tick(1);
    check(sink, 8'h00);
    // the last data bit stays on the pin, so four idle edges shift in ones
    shift8(8'h3C, rd);
    check(rd, 8'h5F);
    switch_mode(1'b1, 8'hA5);
    check({7'h00, mode}, 8'h01);
    check(cfg, 8'hFF);
    shift8(8'h02, rd);
    check(rd, 8'h80);
    strobe();
    check(cfg, 8'h02);
    check({4'h0, ratio}, 8'h05);
    // error read with channel 2 open; serial input high must be ignored
    open_mask = 8'h04;
    i_serial_in = 1'b1;
    i_enable_switch_detect_n = 1'b0;
    // the status settles only after the sinks have been on long enough
    tick(ED_HOLD);
    check({7'h00, det}, 8'h01);
    check(sink, 8'hA5);
    i_enable_switch_detect_n = 1'b1;
    shift8(8'h00, rd);
    check(rd, 8'hA1);
    check(sink, 8'h00);
    check({7'h00, det}, 8'h00);
    check(cfg, 8'h02);
    switch_mode(1'b0, 8'hA5);
    check({7'h00, mode}, 8'h00);
    check(cfg, 8'h02);
    complete_run();
  end
endmodule // led_sink_shift_mode_error_ctrl_tb_top
